// >>> common/sccs_pkg.sv
// Package with register map, field layout, latencies and shared types of the CPU clock switch.
package sccs_pkg;

  // ****************************************************************
  // Register map (byte addresses on the Wishbone bus)
  // ****************************************************************
  localparam logic [3:0] SCCS_ADR_CPU_DIV = 4'h0;
  localparam logic [3:0] SCCS_ADR_SYS_SEL = 4'h4;
  localparam logic [3:0] SCCS_ADR_STATUS = 4'h8;

  localparam int SCCS_SUBSEL_BIT = 0;
  localparam int SCCS_OSCSTOP_BIT = 3;
  localparam int SCCS_DIV_W = 2;

  localparam logic [1:0] SCCS_DIV_RESET = 2'h0;
  localparam logic SCCS_SEL_RESET = 1'b0;

  // ****************************************************************
  // Divide ratios in oscillator ticks per machine cycle, switch latencies in machine cycles
  // ****************************************************************
  localparam int SCCS_RATIO_W = 7;
  localparam logic [6:0] SCCS_RATIO_DIV00 = 7'h40;
  localparam logic [6:0] SCCS_RATIO_DIV01 = 7'h10;
  localparam logic [6:0] SCCS_RATIO_DIV10 = 7'h08;
  localparam logic [6:0] SCCS_RATIO_DIV11 = 7'h04;
  localparam logic [6:0] SCCS_RATIO_SUB = 7'h04;

  localparam int SCCS_LAT_W = 5;
  localparam logic [4:0] SCCS_LAT_DIV00 = 5'h01;
  localparam logic [4:0] SCCS_LAT_DIV01 = 5'h04;
  localparam logic [4:0] SCCS_LAT_DIV10 = 5'h08;
  localparam logic [4:0] SCCS_LAT_DIV11 = 5'h10;
  localparam logic [4:0] SCCS_LAT_FROM_SUB = 5'h01;
  localparam logic [4:0] SCCS_LAT_LAST = 5'h01;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    SCCS_IDLE = 2'b00,
    SCCS_WAIT_CYC = 2'b01,
    SCCS_WAIT_SUB = 2'b11
  } sccs_state_type;

  typedef struct packed {
    logic switch_busy;
    logic main_running;
    logic sub_active;
    logic [1:0] div_active;
  } sccs_status_type;

  localparam int SCCS_ST_BUSY_BIT = 4;

endpackage

// >>> hdl/sccs_tick_div.sv
// Enable-pulse divider that passes every ratio-th input tick.
`timescale 1ns/1ps
module sccs_tick_div
  import sccs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic restart,
  input wire logic tick_in,
  input wire logic [SCCS_RATIO_W-1:0] ratio,
  output logic tick_out
);

  logic [SCCS_RATIO_W-1:0] cnt_r;
  logic last;

  assign last = (cnt_r >= ratio - 7'h01);
  assign tick_out = tick_in && last;

  // A restart aligns the count so the first period after a switch is full length.
  always_ff @(posedge clk)
  begin
    if (!rst_n || restart)
      cnt_r <= '0;
    else if (tick_in)
      cnt_r <= last ? '0 : cnt_r + 7'h01;
  end

endmodule

// >>> hdl/sccs_top.sv
// CPU clock source and divider switch with latency control and main oscillator stop.
`timescale 1ns/1ps
module sccs_top
  import sccs_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic MAIN_OSC_PIN_I,
  output logic MAIN_OSC_PIN_O,
  output logic MAIN_OSC_PIN_OE,
  input wire logic SUB_OSC_IN,
  output logic CPU_CYCLE_TICK,
  output logic SUBCLK_ACTIVE,
  output logic SWITCH_BUSY
);

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  function automatic logic [SCCS_RATIO_W-1:0] main_ratio(input logic [1:0] code);
    unique case (code)
      2'b00: main_ratio = SCCS_RATIO_DIV00;
      2'b01: main_ratio = SCCS_RATIO_DIV01;
      2'b10: main_ratio = SCCS_RATIO_DIV10;
      2'b11: main_ratio = SCCS_RATIO_DIV11;
    endcase
  endfunction

  function automatic logic [SCCS_LAT_W-1:0] div_latency(input logic [1:0] code);
    unique case (code)
      2'b00: div_latency = SCCS_LAT_DIV00;
      2'b01: div_latency = SCCS_LAT_DIV01;
      2'b10: div_latency = SCCS_LAT_DIV10;
      2'b11: div_latency = SCCS_LAT_DIV11;
    endcase
  endfunction

  // ****************************************************************
  // Registers and state
  // ****************************************************************
  logic [1:0] cpu_divider_reg_r;
  logic subclock_select_bit_r;
  logic main_osc_stop_bit_r;
  logic active_sub_r;
  logic [1:0] active_div_r;
  logic [SCCS_LAT_W-1:0] lat_cnt_r;
  sccs_state_type state_r;
  sccs_state_type state_nxt;
  logic [2:0] main_sync_r;
  logic [2:0] sub_sync_r;
  logic ack_r;
  logic [31:0] rdata_r;
  sccs_status_type status;

  logic bus_req;
  logic wr_lo;
  logic fx_tick;
  logic fxt_tick;
  logic main_cyc_tick;
  logic sub_cyc_tick;
  logic cpu_tick;
  logic apply_now;
  logic want_change;

  // ****************************************************************
  // Oscillator inputs, synchronised then edge detected
  // ****************************************************************
  // Bit 0 is only ever read by bit 1; edges use bits 1 and 2.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      main_sync_r <= '0;
      sub_sync_r <= '0;
    end
    else
    begin
      main_sync_r <= {main_sync_r[1:0], MAIN_OSC_PIN_I};
      sub_sync_r <= {sub_sync_r[1:0], SUB_OSC_IN};
    end
  end

  // Stopping the oscillator kills main ticks without any standby entry.
  assign fx_tick = main_sync_r[1] && !main_sync_r[2] && !main_osc_stop_bit_r;
  assign fxt_tick = sub_sync_r[1] && !sub_sync_r[2];

  // While stopped, the input pin is pulled to ground to stop crystal leakage.
  assign MAIN_OSC_PIN_O = 1'b0;
  assign MAIN_OSC_PIN_OE = main_osc_stop_bit_r;

  // ****************************************************************
  // Machine cycle generation
  // ****************************************************************
  sccs_tick_div u_main_div (
    .clk(CLK),
    .rst_n(RST_N),
    .restart(apply_now),
    .tick_in(fx_tick),
    .ratio(main_ratio(active_div_r)),
    .tick_out(main_cyc_tick)
  );

  sccs_tick_div u_sub_div (
    .clk(CLK),
    .rst_n(RST_N),
    .restart(apply_now),
    .tick_in(fxt_tick),
    .ratio(SCCS_RATIO_SUB),
    .tick_out(sub_cyc_tick)
  );

  // One machine cycle is one divided period of whichever clock is active.
  assign cpu_tick = active_sub_r ? sub_cyc_tick : main_cyc_tick;
  assign CPU_CYCLE_TICK = cpu_tick;
  assign SUBCLK_ACTIVE = active_sub_r;

  // ****************************************************************
  // Switch sequencer
  // ****************************************************************
  // The divider is irrelevant while both old and new source are the subclock.
  assign want_change = (subclock_select_bit_r != active_sub_r)
    || (!subclock_select_bit_r && (cpu_divider_reg_r != active_div_r));

  // New settings land on a cycle edge, but a switch to the subclock lands on the next fxT tick, cutting the main cycle.
  assign apply_now = ((state_r == SCCS_WAIT_CYC) && cpu_tick && lat_cnt_r == SCCS_LAT_LAST)
    || ((state_r == SCCS_WAIT_SUB) && fxt_tick);

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      SCCS_IDLE:
      begin
        if (want_change && !active_sub_r && subclock_select_bit_r)
          state_nxt = SCCS_WAIT_SUB;
        else if (want_change)
          state_nxt = SCCS_WAIT_CYC;
      end
      SCCS_WAIT_CYC, SCCS_WAIT_SUB:
      begin
        if (apply_now)
          state_nxt = SCCS_IDLE;
      end
      default: state_nxt = SCCS_IDLE;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      state_r <= SCCS_IDLE;
    else
      state_r <= state_nxt;
  end

  // Latency is set by the setting in force before the switch.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      lat_cnt_r <= SCCS_LAT_LAST;
    else if (state_r == SCCS_IDLE && want_change)
      lat_cnt_r <= active_sub_r ? SCCS_LAT_FROM_SUB : div_latency(active_div_r);
    else if (state_r == SCCS_WAIT_CYC && cpu_tick && lat_cnt_r != SCCS_LAT_LAST)
      lat_cnt_r <= lat_cnt_r - 5'h01;
  end

  // Divider bits written on the subclock follow along silently.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      active_sub_r <= SCCS_SEL_RESET;
      active_div_r <= SCCS_DIV_RESET;
    end
    else if (apply_now)
    begin
      active_sub_r <= subclock_select_bit_r;
      active_div_r <= cpu_divider_reg_r;
    end
    else if (active_sub_r && subclock_select_bit_r)
      active_div_r <= cpu_divider_reg_r;
  end

  assign SWITCH_BUSY = (state_r != SCCS_IDLE);

  // ****************************************************************
  // Wishbone slave
  // ****************************************************************
  assign bus_req = WB_CYC_I && WB_STB_I && !ack_r;
  assign wr_lo = bus_req && WB_WE_I && WB_SEL_I[0];

  // Both bits share one register; software is expected to touch one at a time.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      cpu_divider_reg_r <= SCCS_DIV_RESET;
      subclock_select_bit_r <= SCCS_SEL_RESET;
      main_osc_stop_bit_r <= SCCS_SEL_RESET;
    end
    else if (wr_lo && WB_ADR_I == SCCS_ADR_CPU_DIV)
      cpu_divider_reg_r <= WB_DAT_I[SCCS_DIV_W-1:0];
    else if (wr_lo && WB_ADR_I == SCCS_ADR_SYS_SEL)
    begin
      subclock_select_bit_r <= WB_DAT_I[SCCS_SUBSEL_BIT];
      main_osc_stop_bit_r <= WB_DAT_I[SCCS_OSCSTOP_BIT];
    end
  end

  assign status.switch_busy = SWITCH_BUSY;
  assign status.main_running = !main_osc_stop_bit_r;
  assign status.sub_active = active_sub_r;
  assign status.div_active = active_div_r;

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      ack_r <= 1'b0;
      rdata_r <= '0;
    end
    else
    begin
      ack_r <= bus_req;
      rdata_r <= '0;
      if (bus_req && !WB_WE_I)
      begin
        unique case (WB_ADR_I)
          SCCS_ADR_CPU_DIV: rdata_r <= {30'h0000_0000, cpu_divider_reg_r};
          SCCS_ADR_SYS_SEL: rdata_r <= {28'h000_0000, main_osc_stop_bit_r, 2'b00,
            subclock_select_bit_r};
          SCCS_ADR_STATUS: rdata_r <= {27'h000_0000, status};
          default: rdata_r <= '0;
        endcase
      end
    end
  end

  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = rdata_r;

endmodule

// >>> test/sccs_properties.sv
// Port-level checker of the CPU clock switch.
`timescale 1ns/1ps
module sccs_checker
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic MAIN_OSC_PIN_O,
  input wire logic MAIN_OSC_PIN_OE,
  input wire logic CPU_CYCLE_TICK,
  input wire logic SUBCLK_ACTIVE,
  input wire logic SWITCH_BUSY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  a_ack_latency:
    assert property (WB_ACK_O == $past(WB_CYC_I && WB_STB_I && !WB_ACK_O)) else $error("bad ack");
  a_ack_single:
    assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
  a_data_idle:
    assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0000_0000) else $error("data outside ack");
  a_pin_ground:
    assert property (MAIN_OSC_PIN_OE |-> !MAIN_OSC_PIN_O) else $error("pin not low");
  a_stop_by_write:
    assert property ($changed(MAIN_OSC_PIN_OE) |-> $past(WB_CYC_I && WB_STB_I))
      else $error("stop bit moved without a write");
  a_reset_clear:
    assert property ($rose(RST_N) |-> !(SUBCLK_ACTIVE || SWITCH_BUSY || MAIN_OSC_PIN_OE))
      else $error("state after reset");
  a_switch_bound:
    assert property ($rose(SWITCH_BUSY) |-> ##[1:400] !SWITCH_BUSY) else $error("switch hangs");
  a_source_held:
    assert property ($changed(SUBCLK_ACTIVE) |-> $past(SWITCH_BUSY) || $past(SWITCH_BUSY, 2))
      else $error("source changed unasked");
  a_stop_halts:
    assert property (!SUBCLK_ACTIVE && MAIN_OSC_PIN_OE && $past(MAIN_OSC_PIN_OE, 4)
      |-> !CPU_CYCLE_TICK) else $error("tick while stopped");
  a_tick_pulse:
    assert property (CPU_CYCLE_TICK |=> !CPU_CYCLE_TICK) else $error("tick too long");
  c_to_sub: cover property ($rose(SUBCLK_ACTIVE));
  c_to_main: cover property ($fell(SUBCLK_ACTIVE));
  c_stop: cover property ($rose(MAIN_OSC_PIN_OE));
endmodule
bind sccs_top sccs_checker sccs_checker_inst (.CLK(CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .MAIN_OSC_PIN_O(MAIN_OSC_PIN_O), .MAIN_OSC_PIN_OE(MAIN_OSC_PIN_OE),
  .CPU_CYCLE_TICK(CPU_CYCLE_TICK), .SUBCLK_ACTIVE(SUBCLK_ACTIVE), .SWITCH_BUSY(SWITCH_BUSY));

// >>> test/sccs_top_tb.sv
// Self-checking bench of the CPU clock switch.
`timescale 1ns/1ps
module sccs_top_tb
  import sccs_pkg::*;
;
  logic clk, rst_n, cyc, stb, we, ack, pin_o, pin_oe, tick, subact, busy;
  logic [3:0] adr, sel;
  logic [31:0] dat_i, dat_o, rd;
  logic [1:0] fx_cnt = '0;
  logic [6:0] sub_cnt = '0;
  int num_errors, n_checks, cyc_cnt, n, c, p, i;
  // ****************************************************************
  // Oscillators: fx is CLK/4, fxT is CLK/80; the stop bit grounds fx.
  // ****************************************************************
  wire logic pin_lvl = pin_oe ? pin_o : fx_cnt[1];
  wire logic sub_in = sub_cnt < 7'h28;
  sccs_top sccs_top_inst (.CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o),
    .WB_ACK_O(ack), .MAIN_OSC_PIN_I(pin_lvl), .MAIN_OSC_PIN_O(pin_o),
    .MAIN_OSC_PIN_OE(pin_oe), .SUB_OSC_IN(sub_in), .CPU_CYCLE_TICK(tick),
    .SUBCLK_ACTIVE(subact), .SWITCH_BUSY(busy));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
  begin
    fx_cnt <= fx_cnt + 2'h1;
    sub_cnt <= (sub_cnt == 7'h4F) ? 7'h00 : sub_cnt + 7'h01;
    cyc_cnt++;
    if (cyc_cnt == 40000)
    begin
      num_errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Request is held until ack is sampled, then one idle cycle follows.
  task automatic wb(input logic [3:0] a, input logic w, input logic [3:0] s,
    input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat_i <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
    wb(a, 1'b0, 4'hF, 32'h0000_0000);
    chk(rd, e);
  endtask
  // Counts machine cycles and clocks spent while the switch is pending.
  task automatic sw(input logic [3:0] a, input logic [31:0] d);
    wb(a, 1'b1, 4'hF, d);
    n = 0;
    c = 0;
    do
    begin
      if (tick === 1'b1 && busy === 1'b1)
        n++;
      c++;
      @(posedge clk);
    end
    while (busy !== 1'b0 && c < 1000);
  endtask
  task automatic per();
    do @(posedge clk); while (tick !== 1'b1);
    p = 0;
    do
    begin
      @(posedge clk);
      p++;
    end
    while (tick !== 1'b1);
  endtask
  logic [1:0] nd [4] = '{2'h3, 2'h2, 2'h1, 2'h0};
  logic [4:0] lat [4] = '{SCCS_LAT_DIV00, SCCS_LAT_DIV11, SCCS_LAT_DIV10, SCCS_LAT_DIV01};
  logic [6:0] rat [4] = '{SCCS_RATIO_DIV11, SCCS_RATIO_DIV10, SCCS_RATIO_DIV01, SCCS_RATIO_DIV00};
  initial
  begin
    {rst_n, cyc, stb, we, adr, sel, dat_i} = '0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdchk(SCCS_ADR_CPU_DIV, 32'h0000_0000);
    rdchk(SCCS_ADR_SYS_SEL, 32'h0000_0000);
    rdchk(SCCS_ADR_STATUS, 32'h0000_0008);
    rdchk(4'hC, 32'h0000_0000);
    $display("reset and map test ended");
    for (i = 0; i < 4; i++)
    begin
      sw(SCCS_ADR_CPU_DIV, {30'h0, nd[i]});
      chk(n, lat[i]);
      per();
      chk(p, rat[i] * 4);
      rdchk(SCCS_ADR_STATUS, {30'h0, nd[i]} | 32'h0000_0008);
    end
    wb(SCCS_ADR_CPU_DIV, 1'b1, 4'h0, 32'h0000_0003);
    rdchk(SCCS_ADR_CPU_DIV, 32'h0000_0000);
    $display("divider test ended");
    sw(SCCS_ADR_CPU_DIV, 32'h0000_0002);
    sw(SCCS_ADR_SYS_SEL, 32'h0000_0001);
    chk(c > 90, 0);
    chk(subact, 1);
    wb(SCCS_ADR_CPU_DIV, 1'b1, 4'hF, 32'h0000_0003);
    chk(busy, 0);
    per();
    chk(p, SCCS_RATIO_SUB * 80);
    wb(SCCS_ADR_SYS_SEL, 1'b1, 4'hF, 32'h0000_0009);
    chk(pin_oe, 1);
    chk(pin_o, 0);
    wb(SCCS_ADR_SYS_SEL, 1'b1, 4'hF, 32'h0000_0001);
    chk(pin_oe, 0);
    sw(SCCS_ADR_SYS_SEL, 32'h0000_0000);
    chk(n, SCCS_LAT_FROM_SUB);
    per();
    chk(p, SCCS_RATIO_DIV11 * 4);
    $display("subclock test ended");
    wb(SCCS_ADR_SYS_SEL, 1'b1, 4'hF, 32'h0000_0008);
    n = 0;
    repeat (600)
    begin
      @(posedge clk);
      n += (tick === 1'b1);
    end
    chk(n, 0);
    wb(SCCS_ADR_SYS_SEL, 1'b1, 4'hF, 32'h0000_0000);
    per();
    chk(p, SCCS_RATIO_DIV11 * 4);
    $display("stop test ended");
    stop_test();
  end
endmodule
